// ---- logic/pbc_map.svh ----
`ifndef PBC_MAP_SVH
`define PBC_MAP_SVH

// Register word addresses
`define PBC_ADDR_BLANK_CTRL   4'h0
`define PBC_ADDR_BLANK_DELAY  4'h1
`define PBC_ADDR_AUX_CTRL     4'h2
`define PBC_ADDR_OUT_LEVELS   4'h3

// Blanking control fields
`define PBC_BIT_HI_RISE       15
`define PBC_BIT_HI_FALL       14
`define PBC_BIT_LO_RISE       13
`define PBC_BIT_LO_FALL       12
`define PBC_BIT_FAULT_BLANK   11
`define PBC_BIT_CURLIM_BLANK  10
`define PBC_BIT_SEL_HIGH      5
`define PBC_BIT_SEL_LOW       4
`define PBC_BIT_HI_OUT_HIGH   3
`define PBC_BIT_HI_OUT_LOW    2
`define PBC_BIT_LO_OUT_HIGH   1
`define PBC_BIT_LO_OUT_LOW    0
`define PBC_BLANK_CTRL_MASK   16'hFC3F

// Delay and auxiliary fields
`define PBC_DELAY_MASK        16'h0FFF
`define PBC_AUX_MASK          16'h0F3F
`define PBC_STATE_SRC_LSB     8
`define PBC_CHOP_SRC_LSB      2
`define PBC_BIT_HI_CHOP       1
`define PBC_BIT_LO_CHOP       0

// Output level register fields
`define PBC_OUT_LEVELS_MASK   16'h000F
`define PBC_FAULT_LVL_LSB     2
`define PBC_CURLIM_LVL_LSB    0

// Reset value of every register
`define PBC_RESET_VALUE       16'h0000

`endif

// ---- logic/pbc_pkg.sv ----
`default_nettype none
package pbc_pkg;
   typedef logic [3:0]  pbc_sel_t;
   typedef logic [11:0] pbc_count_t;
   typedef logic [15:0] pbc_word_t;
   // Source codes shared by state-blank and chop selectors
   typedef enum logic [3:0] {
      PBC_SRC_NONE = 4'h0,
      PBC_SRC_GEN1 = 4'h1,
      PBC_SRC_GEN2 = 4'h2,
      PBC_SRC_GEN3 = 4'h3
   } pbc_src_t;
endpackage
`default_nettype wire

// ---- logic/pbc_src_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Source selection bundle between top and selector
interface pbc_src_if;
   logic [3:0] code;
   logic       base;
   logic [2:0] gen_hi;
   logic       sel;
   modport user (output code, output base, output gen_hi, input sel);
   modport mux  (input code, input base, input gen_hi, output sel);
endinterface
`default_nettype wire

// ---- logic/pbc_src_mux.sv ----
`timescale 1ns/100ps
`default_nettype none
// Picks base source or a generator high-side output; reserved codes give 0
module pbc_src_mux
   import pbc_pkg::*;
(
   pbc_src_if.mux s
);
   always_comb begin
      case (s.code)
         PBC_SRC_NONE: s.sel = s.base;
         PBC_SRC_GEN1: s.sel = s.gen_hi[0];
         PBC_SRC_GEN2: s.sel = s.gen_hi[1];
         PBC_SRC_GEN3: s.sel = s.gen_hi[2];
         default:      s.sel = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- logic/pbc_top.sv ----
// Functional notes
// [R1] Four edge enables start blanking counter
// [R2] Fault blank enable lets counter mask fault
// [R3] Current-limit blank enable lets counter mask limit
// [R4] Twelve-bit delay, upper four bits zero
// [R5] Mask while selected blank signal high
// [R6] Mask while selected blank signal low
// [R7] Mask on own high-side output level
// [R8] Mask on own low-side output level
// [R9] State source: none, generator 1-3, reserved
// [R10] Selected signal masks only when enabled
// [R11] Chop source: chop clock, generator 1-3
// [R12] Chop source gates chop-enabled outputs
// [R13] High-side chop enable bit
// [R14] Low-side chop enable bit
// [R15] Active fault forces fault output levels
// [R16] Active current-limit forces limit levels
// [R17] Edge loads counter, masks until zero
// [R18] Chop ANDed after other output processing
// [R19] Config clears on reset, unused bits zero
`timescale 1ns/100ps
`default_nettype none
`include "pbc_map.svh"
module pbc_top
   import pbc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [15:0] reg_rdata,
   // Generator signals, same clock
   input  wire logic        gen_hi,
   input  wire logic        gen_lo,
   input  wire logic [2:0]  gen_peer_hi,
   input  wire logic        chop_clk,
   // Protection inputs, qualified by upstream logic
   input  wire logic        fault_in,
   input  wire logic        curlim_in,
   // Conditioned outputs
   output var  logic        fault_active,
   output var  logic        curlim_active,
   output var  logic        blank_busy,
   output var  logic        high_side_output,
   output var  logic        low_side_output
);

   ////////////////////////////////////////////////////////////////////
   // Registers

   pbc_word_t  blank_ctrl_q;
   pbc_word_t  blank_delay_q;
   pbc_word_t  aux_ctrl_q;
   pbc_word_t  out_levels_q;

   // Blanking control, unimplemented bits dropped
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         blank_ctrl_q <= `PBC_RESET_VALUE; // R19
      end else if (reg_wr && (reg_addr == `PBC_ADDR_BLANK_CTRL)) begin
         blank_ctrl_q <= reg_wdata & `PBC_BLANK_CTRL_MASK; // R19
      end
   end

   // Blanking delay, only the twelve count bits kept
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         blank_delay_q <= `PBC_RESET_VALUE; // R19
      end else if (reg_wr && (reg_addr == `PBC_ADDR_BLANK_DELAY)) begin
         blank_delay_q <= reg_wdata & `PBC_DELAY_MASK; // R4
      end
   end

   // Source selectors and chop enables
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aux_ctrl_q <= `PBC_RESET_VALUE; // R19
      end else if (reg_wr && (reg_addr == `PBC_ADDR_AUX_CTRL)) begin
         aux_ctrl_q <= reg_wdata & `PBC_AUX_MASK; // R19
      end
   end

   // Forced pin levels for fault and current limit
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         out_levels_q <= `PBC_RESET_VALUE; // R19
      end else if (reg_wr && (reg_addr == `PBC_ADDR_OUT_LEVELS)) begin
         out_levels_q <= reg_wdata & `PBC_OUT_LEVELS_MASK;
      end
   end

   pbc_word_t  rd_word;

   // Read mux, unmapped addresses read zero
   always_comb begin
      case (reg_addr)
         `PBC_ADDR_BLANK_CTRL:  rd_word = blank_ctrl_q;
         `PBC_ADDR_BLANK_DELAY: rd_word = blank_delay_q; // R4
         `PBC_ADDR_AUX_CTRL:    rd_word = aux_ctrl_q;
         `PBC_ADDR_OUT_LEVELS:  rd_word = out_levels_q;
         default:               rd_word = `PBC_RESET_VALUE; // R19
      endcase
   end

   // Read data stands only in the cycle after the strobe
   // Zero between reads keeps an idle bus free of stale words
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_word;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Field decode

   logic       hi_rise_trig_en;
   logic       hi_fall_trig_en;
   logic       lo_rise_trig_en;
   logic       lo_fall_trig_en;
   logic       fault_blank_en;
   logic       curlim_blank_en;
   logic       blank_on_sel_high;
   logic       blank_on_sel_low;
   logic       blank_when_hi_out_high;
   logic       blank_when_hi_out_low;
   logic       blank_when_lo_out_high;
   logic       blank_when_lo_out_low;
   pbc_count_t blank_delay_count;
   pbc_sel_t   state_blank_source;
   pbc_sel_t   chop_source;
   logic       hi_chop_en;
   logic       lo_chop_en;
   logic [1:0] fault_out_levels;
   logic [1:0] curlim_out_levels;

   // Field views of the configuration words
   assign hi_rise_trig_en        = blank_ctrl_q[`PBC_BIT_HI_RISE];
   assign hi_fall_trig_en        = blank_ctrl_q[`PBC_BIT_HI_FALL];
   assign lo_rise_trig_en        = blank_ctrl_q[`PBC_BIT_LO_RISE];
   assign lo_fall_trig_en        = blank_ctrl_q[`PBC_BIT_LO_FALL];
   assign fault_blank_en         = blank_ctrl_q[`PBC_BIT_FAULT_BLANK];
   assign curlim_blank_en        = blank_ctrl_q[`PBC_BIT_CURLIM_BLANK];
   assign blank_on_sel_high      = blank_ctrl_q[`PBC_BIT_SEL_HIGH];
   assign blank_on_sel_low       = blank_ctrl_q[`PBC_BIT_SEL_LOW];
   assign blank_when_hi_out_high = blank_ctrl_q[`PBC_BIT_HI_OUT_HIGH];
   assign blank_when_hi_out_low  = blank_ctrl_q[`PBC_BIT_HI_OUT_LOW];
   assign blank_when_lo_out_high = blank_ctrl_q[`PBC_BIT_LO_OUT_HIGH];
   assign blank_when_lo_out_low  = blank_ctrl_q[`PBC_BIT_LO_OUT_LOW];
   assign blank_delay_count      = blank_delay_q[11:0];
   assign state_blank_source     = aux_ctrl_q[`PBC_STATE_SRC_LSB +: 4];
   assign chop_source            = aux_ctrl_q[`PBC_CHOP_SRC_LSB +: 4];
   assign hi_chop_en             = aux_ctrl_q[`PBC_BIT_HI_CHOP];
   assign lo_chop_en             = aux_ctrl_q[`PBC_BIT_LO_CHOP];
   assign fault_out_levels       = out_levels_q[`PBC_FAULT_LVL_LSB +: 2];
   assign curlim_out_levels      = out_levels_q[`PBC_CURLIM_LVL_LSB +: 2];

   ////////////////////////////////////////////////////////////////////
   // Source selectors

   // One selector each for state blanking and chop
   pbc_src_if state_src ();
   pbc_src_if chop_src ();

   // Code 0 of the state selector means no source
   assign state_src.code   = state_blank_source; // R9
   assign state_src.base   = 1'b0;
   assign state_src.gen_hi = gen_peer_hi;
   assign chop_src.code    = chop_source; // R11
   assign chop_src.base    = chop_clk;
   assign chop_src.gen_hi  = gen_peer_hi;

   // Reserved codes select a constant low
   pbc_src_mux u_state_mux (
      .s (state_src)
   );

   pbc_src_mux u_chop_mux (
      .s (chop_src)
   );

   ////////////////////////////////////////////////////////////////////
   // Leading-edge blanking counter

   logic       hi_prev_q;
   logic       lo_prev_q;
   logic       edge_trig;
   pbc_count_t blank_cnt_q;
   pbc_count_t blank_cnt_d;

   // Previous output levels for edge detection
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hi_prev_q <= 1'b0;
         lo_prev_q <= 1'b0;
      end else begin
         hi_prev_q <= gen_hi;
         lo_prev_q <= gen_lo;
      end
   end

   logic       hi_rise;
   logic       hi_fall;
   logic       lo_rise;
   logic       lo_fall;

   // Raw edges against the level seen one clock earlier
   // Previous levels clear to low, so an input already high after reset reads as a rising edge
   assign hi_rise = gen_hi & ~hi_prev_q;
   assign hi_fall = ~gen_hi & hi_prev_q;
   assign lo_rise = gen_lo & ~lo_prev_q;
   assign lo_fall = ~gen_lo & lo_prev_q;

   // Enabled edges only; a cleared enable ignores its edge
   assign edge_trig = (hi_rise_trig_en & hi_rise)
                    | (hi_fall_trig_en & hi_fall)
                    | (lo_rise_trig_en & lo_rise)
                    | (lo_fall_trig_en & lo_fall); // R1

   // Load on edge, count down to zero
   // A fresh edge reloads, so blanking restarts
   always_comb begin
      if (edge_trig) begin
         blank_cnt_d = blank_delay_count; // R17
      end else if (blank_cnt_q != 12'h000) begin
         blank_cnt_d = blank_cnt_q - 12'h001; // R17
      end else begin
         blank_cnt_d = 12'h000;
      end
   end

   // Blanking counter register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         blank_cnt_q <= 12'h000;
      end else begin
         blank_cnt_q <= blank_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Masking

   logic leb_mask;
   logic state_mask;
   logic fault_mask;
   logic curlim_mask;
   logic fault_eff;
   logic curlim_eff;

   // Mask already in the edge cycle, so the first clock is covered
   assign leb_mask = edge_trig ? (blank_delay_count != 12'h000)
                               : (blank_cnt_q != 12'h000); // R17

   logic sel_active;
   logic sel_mask;
   logic own_mask;

   // Code zero turns the selected-signal blanking off
   assign sel_active = (state_blank_source != 4'h0); // R9

   // Blanking while the selected signal sits at a chosen level
   assign sel_mask = (blank_on_sel_high & sel_active &  state_src.sel) // R5 R10
                   | (blank_on_sel_low  & sel_active & ~state_src.sel); // R6 R10

   // Blanking while this channel's own outputs sit at a chosen level
   assign own_mask = (blank_when_hi_out_high &  gen_hi) // R7
                   | (blank_when_hi_out_low  & ~gen_hi) // R7
                   | (blank_when_lo_out_high &  gen_lo) // R8
                   | (blank_when_lo_out_low  & ~gen_lo); // R8

   // State blanking covers both inputs whatever the edge enables say
   assign state_mask = sel_mask | own_mask;

   // Masked conditions never reach pins or flags
   assign fault_mask  = (fault_blank_en & leb_mask) | state_mask; // R2
   assign curlim_mask = (curlim_blank_en & leb_mask) | state_mask; // R3
   assign fault_eff   = fault_in & ~fault_mask;
   assign curlim_eff  = curlim_in & ~curlim_mask;

   ////////////////////////////////////////////////////////////////////
   // Output processing

   logic hi_forced;
   logic lo_forced;
   logic hi_d;
   logic lo_d;

   // Fault wins over current limit
   always_comb begin
      if (fault_eff) begin
         hi_forced = fault_out_levels[1]; // R15
         lo_forced = fault_out_levels[0]; // R15
      end else if (curlim_eff) begin
         hi_forced = curlim_out_levels[1]; // R16
         lo_forced = curlim_out_levels[0]; // R16
      end else begin
         hi_forced = gen_hi;
         lo_forced = gen_lo;
      end
   end

   // Chop gates last, so a forced high level is chopped too
   always_comb begin
      hi_d = hi_forced;
      lo_d = lo_forced;
      if (hi_chop_en) begin
         hi_d = hi_forced & chop_src.sel; // R12 R13 R18
      end
      if (lo_chop_en) begin
         lo_d = lo_forced & chop_src.sel; // R12 R14 R18
      end
   end

   // Pin outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         high_side_output <= 1'b0;
         low_side_output  <= 1'b0;
      end else begin
         high_side_output <= hi_d;
         low_side_output  <= lo_d;
      end
   end

   // Status flags, one cycle behind the inputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fault_active  <= 1'b0;
         curlim_active <= 1'b0;
         blank_busy    <= 1'b0;
      end else begin
         fault_active  <= fault_eff;
         curlim_active <= curlim_eff;
         blank_busy    <= leb_mask;
      end
   end

endmodule
`default_nettype wire

// ---- test/pbc_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module pbc_top_sva (
   // Clock, reset and register port
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Generator and protection inputs
   input wire logic        gen_hi,
   input wire logic        gen_lo,
   input wire logic [2:0]  gen_peer_hi,
   input wire logic        chop_clk,
   input wire logic        fault_in,
   input wire logic        curlim_in,
   // Conditioned outputs
   input wire logic        fault_active,
   input wire logic        curlim_active,
   input wire logic        blank_busy,
   input wire logic        high_side_output,
   input wire logic        low_side_output
);
   logic [15:0] ctl_q, aux_q, lvl_q, dly_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Shadow copies of the configuration words
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctl_q <= 16'h0000;
         dly_q <= 16'h0000;
         aux_q <= 16'h0000;
         lvl_q <= 16'h0000;
      end else if (reg_wr) begin
         if (reg_addr == 4'h0) ctl_q <= reg_wdata;
         if (reg_addr == 4'h1) dly_q <= reg_wdata & 16'h0FFF;
         if (reg_addr == 4'h2) aux_q <= reg_wdata;
         if (reg_addr == 4'h3) lvl_q <= reg_wdata;
      end
   end
   chk_fault_open: assert property (fault_in && ctl_q == 16'h0000 |=> fault_active)
      else $error("fault masked without enable");
   chk_limit_open: assert property (curlim_in && ctl_q == 16'h0000 |=> curlim_active)
      else $error("limit masked without enable");
   chk_idle_quiet: assert property (!fault_in |=> !fault_active)
      else $error("fault flag without cause");
   chk_read_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   chk_delay_top: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[15:12] == 4'h0)
      else $error("delay upper bits not zero");
   chk_blank_start: assert property ($rose(gen_hi) && ctl_q[15] && dly_q != 16'h0000 |=> blank_busy [*2])
      else $error("rising edge did not blank");
   chk_fault_level: assert property (fault_in && ctl_q == 16'h0000 && aux_q[1:0] == 2'b00
      |=> high_side_output == $past(lvl_q[3]) && low_side_output == $past(lvl_q[2]))
      else $error("fault levels not driven");
   chk_chop_gate: assert property (!chop_clk && aux_q[5:1] == 5'b00001 |=> !high_side_output)
      else $error("chop did not gate high side");
   chk_plain_path: assert property (!fault_in && !curlim_in && aux_q[1:0] == 2'b00
      |=> high_side_output == $past(gen_hi) && low_side_output == $past(gen_lo))
      else $error("outputs not following generator");
endmodule
bind pbc_top pbc_top_sva pbc_top_sva_i (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .gen_hi, .gen_lo, .gen_peer_hi, .chop_clk, .fault_in, .curlim_in, .fault_active,
   .curlim_active, .blank_busy, .high_side_output, .low_side_output);
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk_sys, reset, reg_wr, reg_rd, gen_hi, gen_lo, chop_clk, fault_in, curlim_in;
   logic        fault_active, curlim_active, blank_busy, high_side_output, low_side_output;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_q;
   logic [2:0]  gen_peer_hi;
   logic [15:0] msk [6] = '{16'hFC3F, 16'h0FFF, 16'h0F3F, 16'h000F, 16'h0000, 16'h0000};
   logic [3:0]  pat [3] = '{4'h5, 4'hA, 4'h3};
   int          mismatches, compares, i, j, k;
   logic        e;
   pbc_top pbc_top_i (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .gen_hi, .gen_lo, .gen_peer_hi, .chop_clk, .fault_in, .curlim_in, .fault_active,
      .curlim_active, .blank_busy, .high_side_output, .low_side_output);
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_q = reg_rdata;
   endtask
   task automatic flags(input logic [15:0] exp);
      @(posedge clk_sys);
      #1 check(16'({fault_active, curlim_active, blank_busy}), exp);
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog, well beyond the 360 cycles the tests take
   initial begin
      #200000;
      mismatches++;
      results();
   end
   // Main sequence
   initial begin
      {reset, reg_wr, reg_rd, gen_hi, gen_lo, chop_clk, fault_in, curlim_in} = 8'h80;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      gen_peer_hi = 3'h0;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      for (i = 0; i < 6; i++) begin
         rd(4'(i));
         check(rd_q, 16'h0000);
      end
      for (i = 0; i < 6; i++) wr(4'(i), 16'hFFFF);
      for (i = 0; i < 6; i++) begin
         rd(4'(i));
         check(rd_q, msk[i]);
      end
      for (i = 0; i < 4; i++) wr(4'(i), 16'h0000);
      // Chop source codes, reserved one included
      @(posedge clk_sys);
      gen_hi <= 1'b1;
      gen_lo <= 1'b1;
      for (i = 0; i < 5; i++) for (j = 0; j < 3; j++) begin
         wr(4'h2, 16'(i * 4 + 3));
         @(posedge clk_sys);
         chop_clk <= pat[j][3];
         gen_peer_hi <= pat[j][2:0];
         e = i == 0 ? pat[j][3] : (i < 4 ? pat[j][i - 1] : 1'b0);
         @(posedge clk_sys);
         #1 check(16'({high_side_output, low_side_output}), 16'({2{e}}));
      end
      // Forced levels and fault priority
      wr(4'h2, 16'h0000);
      wr(4'h3, 16'h0009);
      @(posedge clk_sys);
      curlim_in <= 1'b1;
      @(posedge clk_sys);
      #1 check(16'({fault_active, curlim_active, high_side_output, low_side_output}), 16'h5);
      @(posedge clk_sys);
      fault_in <= 1'b1;
      @(posedge clk_sys);
      #1 check(16'({fault_active, curlim_active, high_side_output, low_side_output}), 16'hE);
      // Leading-edge blanking per edge type and per masked input
      wr(4'h1, 16'h0003);
      for (i = 0; i < 4; i++) for (j = 10; j < 12; j++) begin
         e = i % 2 == 0;
         @(posedge clk_sys);
         gen_hi <= e;
         gen_lo <= e;
         wr(4'h0, 16'((1 << (15 - i)) | (1 << j)));
         repeat (6) @(posedge clk_sys);
         if (i < 2) gen_hi <= !e;
         else gen_lo <= !e;
         flags(16'h6);
         @(posedge clk_sys);
         if (i < 2) gen_hi <= e;
         else gen_lo <= e;
         for (k = 0; k < 5; k++) flags(16'({j == 10 || k > 3, j == 11 || k > 3, k < 4}));
      end
      // State blanking by selected generator
      for (i = 0; i < 5; i++) for (j = 0; j < 2; j++) begin
         wr(4'h2, 16'(i << 8));
         wr(4'h0, j ? 16'h0020 : 16'h0010);
         @(posedge clk_sys);
         gen_peer_hi <= (i % 4 ? 3'h1 << (i - 1) : 3'h7) ^ {3{!j[0]}};
         @(posedge clk_sys);
         flags((i == 0 || (i == 4 && j == 1)) ? 16'h6 : 16'h0);
      end
      // State blanking by own output levels
      wr(4'h2, 16'h0000);
      for (i = 0; i < 4; i++) for (j = 0; j < 2; j++) begin
         wr(4'h0, 16'(1 << i));
         @(posedge clk_sys);
         gen_hi <= i > 1 ? j[0] ~^ i[0] : 1'b0;
         gen_lo <= i < 2 ? j[0] ~^ i[0] : 1'b0;
         @(posedge clk_sys);
         flags(j ? 16'h0 : 16'h6);
      end
      results();
   end
endmodule
`default_nettype wire
